// >>> src/srws_map.svh
// constants of the supervisor: timing figures and derived cycle counts
// assumes a single 250 MHz system clock; included by its bare name
`ifndef SRWS_MAP_SVH
`define SRWS_MAP_SVH

// system clock period in ns and rate in MHz
`define SRWS_CLK_NS 4
`define SRWS_CLK_MHZ 250

// default timeout period in ms, and its count of clock cycles
`define SRWS_TIMEOUT_MS 100
`define SRWS_TIMEOUT_CYCLES (`SRWS_TIMEOUT_MS * 1000 * `SRWS_CLK_MHZ)

// least low time of a kick pulse in ns, rounded up to whole cycles
`define SRWS_KICK_NS 150
`define SRWS_KICK_CYCLES ((`SRWS_KICK_NS + `SRWS_CLK_NS - 1) / `SRWS_CLK_NS)

// debounce delay is the timeout period divided by 2**6 = 64
`define SRWS_DEBOUNCE_SHIFT 6

// reset value of the synchronised comparator flags and kick line
`define SRWS_SYNC_RESET 1'h0

`endif

// >>> src/srws_pkg.sv
// types shared by the supervisor modules
// assumes srws_map.svh supplies the numeric constants
package srws_pkg;

    // sequencer states
    typedef enum logic [2:0] {
        ST_RAMP = 3'b000,  // supply ramping, everything asserted
        ST_DEBOUNCE = 3'b001,  // debounce delay before warning release
        ST_INIT = 3'b010,  // initialization reset period
        ST_RUN = 3'b011,  // watchdog running, resets released
        ST_TORESET = 3'b100  // timeout reset asserted
    } srws_state_e;

    // comparator status flags, high when the level is above its threshold
    typedef struct packed {
        logic vddAboveOn;  // supply above its on level
        logic vddAboveOff;  // supply above its off level
        logic vinAboveStart;  // monitored input above start threshold
        logic vinAboveWarn;  // monitored input above warn threshold
        logic vinAboveLow;  // monitored input above low threshold
    } srws_cmp_s;

    // open-drain pin: out level and enable (high while driving)
    typedef struct packed {
        logic out;
        logic oe;
    } srws_pin_s;

endpackage

// >>> src/srws_sync.sv
// two-flop synchroniser for a group of level inputs
// assumes the inputs are quasi-static with respect to sys_clk
`timescale 1ns/1ps
`include "srws_map.svh"
module srws_sync #(
    parameter int W = 1
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [W-1:0] asyncIn,
    output logic [W-1:0] syncOut
);
    logic [W-1:0] stage1_r;  // read only by the second stage

    // first stage, metastability catcher
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            stage1_r <= {W{`SRWS_SYNC_RESET}};
        end else begin
            stage1_r <= asyncIn;
        end
    end

    // second stage, the only consumer of stage1_r
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            syncOut <= {W{`SRWS_SYNC_RESET}};
        end else begin
            syncOut <= stage1_r;
        end
    end
endmodule

// >>> src/srws_timer.sv
// shared divider chain: counts to a terminal and pulses expire
// assumes the sequencer restarts it on every state change
`timescale 1ns/1ps
module srws_timer #(
    parameter int CNT_W = 32
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic restart,
    input wire logic [CNT_W-1:0] terminal,
    output logic expire
);
    logic [CNT_W-1:0] cnt_r;  // elapsed cycles since restart
    logic [CNT_W-1:0] last;  // count value of the final cycle

    // a zero terminal would only expire after 2**CNT_W cycles; treat it as one cycle
    // expire is not gated by restart: restart is decoded from expire
    // upstream, so gating it here would close a combinational loop
    always_comb begin
        last = (terminal == '0) ? '0 : terminal - {{(CNT_W-1){1'b0}}, 1'b1};
        expire = (cnt_r >= last);
    end

    // count up, wrap on expire so the period repeats on its own
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r <= '0;
        end else if (restart || expire) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end
endmodule

// >>> src/srws_supervisor.sv
// supervisory sequencer: power-up init, voltage warning, self
// recovering watchdog with reset outputs of both polarities.
// assumes comparator flags and kick_n arrive from the analog front
// end asynchronously; arst_n is the supply-low power-on reset.
`timescale 1ns/1ps
`include "srws_map.svh"
module srws_supervisor
    import srws_pkg::*;
#(
    parameter int CNT_W = 32,
    parameter int TIMEOUT_CYCLES = `SRWS_TIMEOUT_CYCLES
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input srws_cmp_s cmpIn,
    input wire logic kick_n,
    input wire logic [CNT_W-1:0] timingTune,
    output logic powerWarn_n,
    output logic cpuHold_n,
    output logic cpuHold,
    output srws_pin_s warnPin,
    output srws_pin_s holdNPin,
    output srws_pin_s holdPin
);
    localparam int KICK_CYCLES = `SRWS_KICK_CYCLES;
    localparam logic [7:0] KICK_LAST = 8'(KICK_CYCLES - 1);

    ////////////////////////////////////////////////////////////////
    // input synchronisation

    srws_cmp_s cmpSync;  // comparator flags in the clock domain
    logic kickSync;  // kick line in the clock domain

    // flags and kick line share one synchroniser bank
    srws_sync #(
        .W($bits(srws_cmp_s) + 1)
    ) u_sync (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .asyncIn({cmpIn, kick_n}),
        .syncOut({cmpSync, kickSync})
    );

    ////////////////////////////////////////////////////////////////
    // kick pulse qualification

    logic kickArmed_r;  // a high level was seen since the last event
    logic [7:0] kickLow_r;  // cycles the kick line has been low
    logic kickEvent;  // one-cycle qualified kick

    // fire once the line has stayed low long enough after being high;
    // a line held constantly low never re-arms
    assign kickEvent = kickArmed_r && !kickSync && (kickLow_r == KICK_LAST);

    // low-time counter, cleared on any high level
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            kickLow_r <= 8'h00;
        end else if (kickSync || !kickArmed_r) begin
            kickLow_r <= 8'h00;
        end else if (kickLow_r != KICK_LAST) begin
            kickLow_r <= kickLow_r + 8'h01;
        end
    end

    // arming: set by a high level, spent by the event
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            kickArmed_r <= 1'b0;
        end else if (kickSync) begin
            kickArmed_r <= 1'b1;
        end else if (kickEvent) begin
            kickArmed_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // timeout period and debounce terminal

    logic [CNT_W-1:0] timeoutTerm;  // active timeout period in cycles
    logic [CNT_W-1:0] debounceTerm;  // debounce delay in cycles
    logic [CNT_W-1:0] timerTerm;  // terminal handed to the timer

    // zero tune selects the default period
    assign timeoutTerm = (timingTune == '0) ? CNT_W'(TIMEOUT_CYCLES) : timingTune;

    // same chain divided by 64, never below one cycle
    always_comb begin
        debounceTerm = timeoutTerm >> `SRWS_DEBOUNCE_SHIFT;
        if (debounceTerm == '0) begin
            debounceTerm = {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    ////////////////////////////////////////////////////////////////
    // sequencer

    srws_state_e state_r;  // current state
    srws_state_e state_nxt;  // next state
    logic timerRestart;  // restart the period on every state change
    logic timerExpire;  // the running period has elapsed
    logic supplyDown;  // supply below its off level
    logic needInit;  // condition that forces a fresh initialization

    assign supplyDown = !cmpSync.vddAboveOff;
    assign needInit = supplyDown || !cmpSync.vddAboveOn || !cmpSync.vinAboveLow;

    // the one timer serves init and watchdog alike
    srws_timer #(
        .CNT_W(CNT_W)
    ) u_timer (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .restart(timerRestart),
        .terminal(timerTerm),
        .expire(timerExpire)
    );

    // debounce uses the short terminal, all else the full period
    assign timerTerm = (state_r == ST_DEBOUNCE) ? debounceTerm : timeoutTerm;
    assign timerRestart = (state_nxt != state_r) || (state_r == ST_RUN && kickEvent);

    // next state; power-down checks come first
    always_comb begin
        state_nxt = state_r;
        if (needInit) begin
            // restart init once the condition clears
            state_nxt = ST_RAMP;
        end else begin
            case (state_r)
                ST_RAMP: begin
                    // supply on and input above start: later event wins
                    if (cmpSync.vinAboveStart) begin
                        state_nxt = ST_DEBOUNCE;
                    end
                end
                ST_DEBOUNCE: begin
                    // input must stay above start through the debounce
                    if (!cmpSync.vinAboveStart) begin
                        state_nxt = ST_RAMP;
                    end else if (timerExpire) begin
                        state_nxt = ST_INIT;
                    end
                end
                ST_INIT: begin
                    // kicks ignored here; only the period ends init
                    if (timerExpire) begin
                        state_nxt = ST_RUN;
                    end
                end
                ST_RUN: begin
                    // a kick restarts the timer, silence times out
                    if (timerExpire && !kickEvent) begin
                        state_nxt = ST_TORESET;
                    end
                end
                ST_TORESET: begin
                    // retry after one period, or at once on a kick
                    if (timerExpire || kickEvent) begin
                        state_nxt = ST_RUN;
                    end
                end
                default: begin
                    state_nxt = ST_RAMP;
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= ST_RAMP;
        end else begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////
    // outputs, decoded from the next state so they move with it

    logic warn_nxt;  // warning asserted next cycle
    logic hold_nxt;  // resets asserted next cycle

    // warning tracks the warn comparator once debounce is over
    always_comb begin
        case (state_nxt)
            ST_RAMP, ST_DEBOUNCE: begin
                warn_nxt = 1'b1;
            end
            default: begin
                warn_nxt = !cmpSync.vinAboveWarn;  // early alert
            end
        endcase
        hold_nxt = (state_nxt != ST_RUN);
    end

    // level outputs; the high reset is always the complement
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            powerWarn_n <= 1'b0;
            cpuHold_n <= 1'b0;
            cpuHold <= 1'b1;
        end else begin
            powerWarn_n <= !warn_nxt;
            cpuHold_n <= !hold_nxt;
            cpuHold <= hold_nxt;
        end
    end

    // open-drain pins: enable pulls low; the high reset pin pulls low
    // while the reset is inactive, so the pull-up shows it asserted
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            warnPin <= '{out: 1'b0, oe: 1'b1};
            holdNPin <= '{out: 1'b0, oe: 1'b1};
            holdPin <= '{out: 1'b0, oe: 1'b0};
        end else begin
            warnPin <= '{out: 1'b0, oe: warn_nxt};
            holdNPin <= '{out: 1'b0, oe: hold_nxt};
            holdPin <= '{out: 1'b0, oe: !hold_nxt};
        end
    end

    ////////////////////////////////////////////////////////////////
    // assertions

    a_ramp_all_asserted: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (state_r == ST_RAMP) |-> (!powerWarn_n && !cpuHold_n && cpuHold))
        else $error("outputs not asserted while ramping");

    a_reset_complement: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        cpuHold == !cpuHold_n)
        else $error("reset outputs not complementary");

    a_debounce_release: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (state_r == ST_DEBOUNCE && timerExpire && !needInit && cmpSync.vinAboveStart
            && cmpSync.vinAboveWarn) |=> (powerWarn_n && !cpuHold_n))
        else $error("warning not released after debounce");

    a_init_release: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (state_r == ST_INIT && timerExpire && !needInit) |=> (cpuHold_n && cpuHold == 1'b0))
        else $error("resets not released after init period");

    a_low_input_reset: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        !cmpSync.vinAboveLow |=> (!cpuHold_n && state_r == ST_RAMP))
        else $error("low input did not assert resets");

    a_supply_off_all: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        supplyDown |=> (!powerWarn_n && !cpuHold_n && cpuHold))
        else $error("supply off did not assert all outputs");

    a_warn_before_reset: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (state_r == ST_RUN && !needInit && !cmpSync.vinAboveWarn && !timerExpire)
            |=> (!powerWarn_n && cpuHold_n))
        else $error("warning not raised ahead of reset");

    a_init_ignores_kick: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (state_r == ST_INIT && kickEvent && !timerExpire && !needInit)
            |=> (state_r == ST_INIT && !cpuHold_n))
        else $error("kick acted during initialization");

    a_timeout_reset: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (state_r == ST_RUN && timerExpire && !kickEvent && !needInit)
            |=> (!cpuHold_n && state_r == ST_TORESET))
        else $error("watchdog timeout did not assert resets");

    a_kick_ends_reset: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (state_r == ST_TORESET && kickEvent && !needInit) |=> cpuHold_n)
        else $error("kick did not end timeout reset");

    a_kick_restarts: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (state_r == ST_RUN && kickEvent && !needInit) |=> (state_r == ST_RUN && cpuHold_n))
        else $error("kick did not restart the watchdog");

endmodule

// >>> tb/srws_cpu_model.sv
// processor model: pulses the active-low watchdog clear line
// assumes the bench sets enable, period and low length at clock edges
`timescale 1ns/1ps
module srws_cpu_model (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic kickEn, // kicking on
    input wire logic [15:0] kickPeriod, // cycles from kick to kick
    input wire logic [15:0] kickLow, // low time of one kick
    output logic kick_n
);
    logic [15:0] phase_r; // position inside the kick period
    ////////////////////////////////////////
    // phase counter, back to zero while idle so a kick starts at once
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            phase_r <= 16'h0;
        end else if (!kickEn || phase_r == kickPeriod - 16'h1) begin
            phase_r <= 16'h0;
        end else begin
            phase_r <= phase_r + 16'h1;
        end
    end
    // line rests high between kicks; a short low time models a glitch
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            kick_n <= 1'h1;
        end else begin
            kick_n <= !(kickEn && phase_r < kickLow);
        end
    end
endmodule

// >>> tb/srws_supervisor_bench.sv
// self-checking bench of the supervisor with a short timeout period
// assumes the processor model in srws_cpu_model.sv drives kick_n
`timescale 1ns/1ps
module srws_supervisor_bench;
    import srws_pkg::*;
    localparam int T = 640; // timeout in cycles, keeps the run short
    localparam int D = T / 64; // debounce delay
    localparam int T2 = 2 * T; // programmed timeout from the brown-out on
    localparam int D2 = T2 / 64; // debounce delay with the programmed timeout
    logic sys_clk;
    logic arst_n;
    srws_cmp_s cmpIn; // comparator levels
    logic kick_n;
    logic [31:0] timingTune;
    logic powerWarn_n, cpuHold_n, cpuHold;
    srws_pin_s warnPin, holdNPin, holdPin;
    logic kickEn;
    logic [15:0] kickPeriod, kickLow;
    int miscompares = 0;
    int cmpCount = 0;
    int cycleCount = 0;
    int n;
    ////////////////////////////////////////
    srws_supervisor #(.CNT_W(32), .TIMEOUT_CYCLES(T)) u_dut (
        .sys_clk(sys_clk), .arst_n(arst_n), .cmpIn(cmpIn), .kick_n(kick_n),
        .timingTune(timingTune), .powerWarn_n(powerWarn_n), .cpuHold_n(cpuHold_n),
        .cpuHold(cpuHold), .warnPin(warnPin), .holdNPin(holdNPin), .holdPin(holdPin)
    );
    srws_cpu_model u_cpu (
        .sys_clk(sys_clk), .arst_n(arst_n), .kickEn(kickEn),
        .kickPeriod(kickPeriod), .kickLow(kickLow), .kick_n(kick_n)
    );
    ////////////////////////////////////////
    // 250 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // hang guard, well above the expected run length
    always @(posedge sys_clk) begin
        cycleCount++;
        if (cycleCount == 20000) begin
            miscompares++;
            report_and_stop();
        end
    end
    // output polarity and open-drain enables, checked every cycle
    always @(negedge sys_clk) begin
        if (arst_n) begin
            chk_bit("cpuHold", ~cpuHold_n, cpuHold);
            chk_bit("holdNPin.oe", ~cpuHold_n, holdNPin.oe);
            chk_bit("holdPin.oe", cpuHold_n, holdPin.oe);
            chk_bit("warnPin.oe", ~powerWarn_n, warnPin.oe);
            chk_bit("warnPin.out", 1'b0, warnPin.out);
            chk_bit("holdNPin.out", 1'b0, holdNPin.out);
            chk_bit("holdPin.out", 1'b0, holdPin.out);
        end
    end
    ////////////////////////////////////////
    task automatic report_and_stop();
        if (miscompares == 0 && cmpCount > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // single-bit result
    task automatic chk_bit(input string name, input logic exp, input logic got);
        cmpCount++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %b seen %b", name, exp, got);
        end
    endtask
    // cycle count within a window
    task automatic chk_cnt(input string name, input int lo, input int hi, input int got);
        cmpCount++;
        if (got < lo || got > hi) begin
            miscompares++;
            $display("[ERR] %s expected %0d..%0d seen %0d", name, lo, hi, got);
        end
    endtask
    // edges until reset (or warning) reaches lvl, bounded by maxc
    task automatic wait_out(input bit useWarn, input logic lvl, input int maxc, output int cnt);
        cnt = 0;
        while (((useWarn ? powerWarn_n : cpuHold_n) !== lvl) && cnt < maxc) begin
            @(posedge sys_clk);
            #1;
            cnt++;
        end
    endtask
    // reset must sit at lvl for cyc cycles; first wrong value reported
    task automatic hold_for(input string name, input int cyc, input logic lvl);
        logic seen;
        seen = lvl;
        repeat (cyc) begin
            @(posedge sys_clk);
            #1;
            if (cpuHold_n !== lvl && seen === lvl) seen = cpuHold_n;
        end
        chk_bit(name, lvl, seen);
    endtask
    task automatic set_cmp(input logic [4:0] v);
        @(posedge sys_clk);
        cmpIn <= srws_cmp_s'(v);
        #1;
    endtask
    // periodic kicks; period FFFF with short enable gives one kick
    task automatic set_kick(input logic en, input logic [15:0] per, input logic [15:0] low);
        @(posedge sys_clk);
        kickEn <= en;
        kickPeriod <= per;
        kickLow <= low;
        #1;
    endtask
    ////////////////////////////////////////
    // power-up: warning waits for the later of supply and input
    task automatic sc_power_up();
        set_kick(1'b1, 16'h64, 16'h28); // kicks during init must not count
        set_cmp(5'h0F);
        repeat (50) @(posedge sys_clk);
        #1;
        chk_bit("powerWarn_n", 1'b0, powerWarn_n);
        set_cmp(5'h1F);
        wait_out(1'b1, 1'b1, 200, n);
        chk_cnt("debounce", D + 1, D + 5, n);
        wait_out(1'b0, 1'b1, 2 * T, n);
        chk_cnt("init hold", T, T, n);
    endtask
    // steady kicks keep reset off; too-short kicks are not seen
    task automatic sc_keep_alive();
        hold_for("cpuHold_n alive", 3 * T, 1'b1);
        set_kick(1'b1, 16'h64, 16'h14);
        wait_out(1'b0, 1'b0, 2 * T, n);
        chk_cnt("short kick timeout", T - 100, T + 45, n);
    endtask
    // no kicks: square wave with both halves one period long
    task automatic sc_square();
        set_kick(1'b0, 16'hFFFF, 16'h0);
        wait_out(1'b0, 1'b1, 2 * T, n);
        wait_out(1'b0, 1'b0, 2 * T, n);
        chk_cnt("released half", T, T, n);
        wait_out(1'b0, 1'b1, 2 * T, n);
        chk_cnt("reset half", T, T, n);
    endtask
    // a glitch leaves the timeout reset; a real kick ends it at once
    task automatic sc_kick_ends_reset();
        wait_out(1'b0, 1'b0, 2 * T, n);
        set_kick(1'b1, 16'hFFFF, 16'h14);
        repeat (60) @(posedge sys_clk);
        #1;
        chk_bit("cpuHold_n glitch", 1'b0, cpuHold_n);
        set_kick(1'b0, 16'hFFFF, 16'h0);
        repeat (5) @(posedge sys_clk);
        set_kick(1'b1, 16'hFFFF, 16'h28);
        wait_out(1'b0, 1'b1, T, n);
        chk_cnt("kick release", 38, 48, n);
        set_kick(1'b0, 16'hFFFF, 16'h0);
        repeat (5) @(posedge sys_clk);
        set_kick(1'b1, 16'h12C, 16'h28);
    endtask
    // falling input: warning first, then reset, then full re-init
    task automatic sc_brown_out();
        set_cmp(5'h1D);
        wait_out(1'b1, 1'b0, 10, n);
        chk_cnt("warn delay", 1, 4, n);
        chk_bit("cpuHold_n on warn", 1'b1, cpuHold_n);
        set_cmp(5'h1C);
        wait_out(1'b0, 1'b0, 10, n);
        chk_cnt("low reset delay", 1, 4, n);
        set_cmp(5'h1F);
        wait_out(1'b1, 1'b1, 200, n);
        chk_cnt("re-init debounce", D2 + 1, D2 + 5, n);
        wait_out(1'b0, 1'b1, 2 * T2, n);
        chk_cnt("re-init hold", T2, T2, n);
    endtask
    // supply off with input high: all asserted, kicks ignored
    task automatic sc_supply_off();
        set_cmp(5'h07);
        wait_out(1'b0, 1'b0, 10, n);
        chk_cnt("off reset delay", 1, 4, n);
        chk_bit("powerWarn_n off", 1'b0, powerWarn_n);
        hold_for("cpuHold_n off", T + T / 2, 1'b0);
        set_cmp(5'h1F);
        wait_out(1'b1, 1'b1, 200, n);
        wait_out(1'b0, 1'b1, 2 * T2, n);
        chk_cnt("off re-init hold", T2, T2, n);
    endtask
    ////////////////////////////////////////
    // main sequence
    initial begin
        arst_n = 1'b0;
        cmpIn = srws_cmp_s'(5'h00);
        timingTune = 32'h0; // zero picks the parameter default
        kickEn = 1'b0;
        kickPeriod = 16'hFFFF;
        kickLow = 16'h0;
        repeat (12) @(posedge sys_clk);
        #1;
        chk_bit("powerWarn_n rst", 1'b0, powerWarn_n);
        chk_bit("cpuHold_n rst", 1'b0, cpuHold_n);
        @(posedge sys_clk);
        arst_n <= 1'b1;
        hold_for("cpuHold_n ramp", 5, 1'b0);
        sc_power_up();
        sc_keep_alive();
        sc_square();
        sc_kick_ends_reset();
        // from here on the programmed terminal replaces the default
        @(posedge sys_clk);
        timingTune <= 32'(T2);
        sc_brown_out();
        sc_supply_off();
        report_and_stop();
    end
endmodule
